// ---- common/cpu_arith_logic_defines.vh ----
// constants for the arithmetic and logic decode core
`ifndef CPU_ARITH_LOGIC_DEFINES_VH
`define CPU_ARITH_LOGIC_DEFINES_VH
// special opcodes
`define OP_NOP 8'h00
`define OP_LONG_JUMP 8'h02
`define OP_LONG_CALL 8'h12
`define OP_REL_JUMP 8'h80
`define OP_CODE_READ_PC 8'h83
`define OP_CODE_READ_DP 8'h93
`define OP_DATA_POINTER_INC 8'hA3
`define OP_PRODUCT 8'hA4
`define OP_QUOTIENT 8'h84
`define OP_DEC_ADJUST 8'hD4
`define OP_CLEAR_ACC 8'hE4
`define OP_CPL_ACC 8'hF4
`define OP_OR_DIR_ACC 8'h42
`define OP_OR_DIR_IMM 8'h43
`define OP_AND_DIR_ACC 8'h52
`define OP_AND_DIR_IMM 8'h53
`define OP_XOR_DIR_ACC 8'h62
`define OP_XOR_DIR_IMM 8'h63
`define OP_BIT_CLEAR 8'hC2
`define OP_BIT_SET 8'hD2
// special function register addresses
`define SFR_ACC 8'hE0
`define SFR_B 8'hF0
`define SFR_PSW 8'hD0
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
// status word bit positions
`define PSW_CARRY 7
`define PSW_HALF 6
`define PSW_WRAP 2
// reset values
`define RST_SP 8'h07
`define RST_PC 16'h0000
// total instruction cycle counts where they differ from byte count
`define CYC_DATA_POINTER_INC 3'd3
`define CYC_MULDIV 3'd5
`define CYC_CODE_READ 3'd3
`endif

// ---- test/cpu_arith_logic_asserts.sv ----
// port assertions for the arithmetic and logic decode core
`timescale 1ns/1ps
module cpu_arith_logic_asserts (
    input wire clock,
    input wire rst_b,
    input wire [7:0] codeData,
    input wire [15:0] codeAddr,
    input wire [7:0] accOut,
    input wire [7:0] bOut,
    input wire [7:0] statusOut,
    input wire [15:0] dataPointerOut,
    input wire [7:0] stackOut,
    input wire instrDone,
    input wire badOpcode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // result timing and side effects
    // ----------------------------------------
    a_bad_with_done: assert property (badOpcode |-> instrDone)
        else $error("bad opcode flag without done");
    a_bad_keeps_regs: assert property (badOpcode |->
        $stable(accOut) && $stable(bOut)) else $error("bad opcode changed");
    a_parity_live: assert property (statusOut[0] == ^accOut)
        else $error("parity bit stale");
    a_acc_at_done: assert property (!$stable(accOut) |-> instrDone)
        else $error("accumulator moved between instructions");
    a_flags_at_done: assert property (!$stable(statusOut) |->
        instrDone) else $error("status moved between instructions");
    a_b_at_done: assert property (!$stable(bOut) |-> instrDone)
        else $error("b register moved between instructions");
    // calls push one byte a cycle, so a first step is followed by a second
    a_call_push_two: assert property (!$stable(stackOut) &&
        $past(stackOut) == $past(stackOut, 2) |->
        stackOut == $past(stackOut) + 8'h01 ##1
        stackOut == $past(stackOut) + 8'h01) else $error("stack pair");
    a_stack_step_one: assert property (!$stable(stackOut) |->
        stackOut == $past(stackOut) + 8'h01) else $error("stack step");
    a_data_pointer_step_one: assert property (!$stable(dataPointerOut) |->
        dataPointerOut == $past(dataPointerOut) + 16'h0001)
        else $error("data pointer step");
    // five cycles is the longest instruction
    a_done_within_five: assert property (!instrDone |->
        ##[1:5] instrDone) else $error("instruction overran");
    c_bad_opcode: cover property (badOpcode);
    c_stack_push: cover property (!$stable(stackOut));
    c_data_pointer_inc: cover property (!$stable(dataPointerOut));
    c_five_cycle: cover property (instrDone ##1 !instrDone [*4] ##1 instrDone);
endmodule // cpu_arith_logic_asserts

bind cpu_arith_logic_decode cpu_arith_logic_asserts u_chk (
    .clock(clock),
    .rst_b(rst_b),
    .codeData(codeData),
    .codeAddr(codeAddr),
    .accOut(accOut),
    .bOut(bOut),
    .statusOut(statusOut),
    .dataPointerOut(dataPointerOut),
    .stackOut(stackOut),
    .instrDone(instrDone),
    .badOpcode(badOpcode)
);

// ---- test/tb.sv ----
// self-checking bench for the arithmetic and logic decode core
`timescale 1ns/1ps
`include "cpu_arith_logic_defines.vh"
module tb;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] rom [0:65535];
    reg [1:0] bank = 2'h0;
    wire [15:0] codeAddr;
    wire [15:0] dataPointerOut;
    wire [7:0] codeData;
    wire [7:0] accOut;
    wire [7:0] bOut;
    wire [7:0] statusOut;
    wire [7:0] stackOut;
    wire instrDone;
    wire badOpcode;
    integer miscompares = 0;
    integer n_tests = 0;
    integer i;
    // ----------------------------------------
    // clock, code memory and core
    // ----------------------------------------
    always #2 clock = ~clock;
    // combinational code memory, answers in the same cycle
    assign codeData = rom[codeAddr];
    cpu_arith_logic_decode u_dut (
        .clock(clock),
        .rst_b(rst_b),
        .codeData(codeData),
        .codeAddr(codeAddr),
        .accOut(accOut),
        .bOut(bOut),
        .statusOut(statusOut),
        .dataPointerOut(dataPointerOut),
        .stackOut(stackOut),
        .instrDone(instrDone),
        .badOpcode(badOpcode)
    );
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task cmp16(input [15:0] g, input [15:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task cmp8(input [7:0] g, input [7:0] e);
        cmp16({8'h00, g}, {8'h00, e});
    endtask
    // bytes are taken from the low n bytes of v, most significant first
    task put(input [15:0] a, input [63:0] v, input integer n);
        for (i = 0; i < n; i = i + 1)
            rom[a + i] = v[8 * (n - 1 - i) +: 8];
    endtask
    // cycles from one done pulse to the next; zero skips the count check
    task step(input [7:0] c);
        reg [7:0] n;
        begin
            n = 8'h00;
            do begin
                @(posedge clock);
                #1;
                n = n + 8'h01;
            end while (instrDone !== 1'b1 && n < 8'h10);
            if (c != 8'h00)
                cmp8(n, c);
        end
    endtask
    // f is carry, half carry, signed wrap
    task ex(input [7:0] c, input [7:0] a, input [2:0] f);
        begin
            step(c);
            cmp8(accOut, a);
            cmp8(statusOut, {f[2], f[1], 1'h0, bank, f[0], 1'h0, ^a});
        end
    endtask
    task boot;
        begin
            rst_b = 1'b0;
            bank = 2'h0;
            repeat (2) @(posedge clock);
            #1;
            cmp16(codeAddr, `RST_PC);
            cmp8(stackOut, `RST_SP);
            cmp8(statusOut, 8'h00);
            rst_b = 1'b1;
            step(8'h00);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_add;
        begin
            put(16'h0000, 64'h00247F2401248034, 8);
            put(16'h0008, 64'h0094029400, 5);
            boot;
            ex(8'h02, 8'h7F, 3'h0);
            ex(8'h02, 8'h80, 3'h3);
            ex(8'h02, 8'h00, 3'h5);
            ex(8'h02, 8'h01, 3'h0);
            ex(8'h02, 8'hFF, 3'h6);
            ex(8'h02, 8'hFE, 3'h0);
            $display("add test done");
        end
    endtask
    task t_mul;
        begin
            put(16'h0000, 64'h0024FF241643F00C, 8);
            put(16'h0008, 64'hA443F010A48453F0, 8);
            put(16'h0010, 64'h0084, 2);
            boot;
            ex(8'h02, 8'hFF, 3'h0);
            ex(8'h02, 8'h15, 3'h6);
            ex(8'h03, 8'h15, 3'h6);
            cmp8(bOut, 8'h0C);
            ex(8'h05, 8'hFC, 3'h2);
            cmp8(bOut, 8'h00);
            ex(8'h03, 8'hFC, 3'h2);
            ex(8'h05, 8'hC0, 3'h3);
            cmp8(bOut, 8'h0F);
            ex(8'h05, 8'h0C, 3'h2);
            cmp8(bOut, 8'h0C);
            ex(8'h03, 8'h0C, 3'h2);
            ex(8'h05, 8'h0C, 3'h3);
            cmp8(bOut, 8'h00);
            $display("multiply divide test done");
        end
    endtask
    task t_logic;
        begin
            put(16'h0000, 64'h0024F02420440F54, 8);
            put(16'h0008, 64'h3C64FF62F00414E4, 8);
            put(16'h0010, 64'hF42401D4, 4);
            boot;
            ex(8'h02, 8'hF0, 3'h0);
            ex(8'h02, 8'h10, 3'h4);
            ex(8'h02, 8'h1F, 3'h4);
            ex(8'h02, 8'h1C, 3'h4);
            ex(8'h02, 8'hE3, 3'h4);
            ex(8'h02, 8'hE3, 3'h4);
            cmp8(bOut, 8'hE3);
            ex(8'h01, 8'hE4, 3'h4);
            ex(8'h01, 8'hE3, 3'h4);
            ex(8'h01, 8'h00, 3'h4);
            ex(8'h01, 8'hFF, 3'h4);
            ex(8'h02, 8'h00, 3'h6);
            ex(8'h01, 8'h66, 3'h6);
            $display("logic test done");
        end
    endtask
    // bank 0 and bank 1 hold different R0 values, so a wrong bank shows
    task t_bank;
        begin
            put(16'h0000, 64'h0053000043001153, 8);
            put(16'h0008, 64'h080043082243D008, 8);
            put(16'h0010, 64'h28532200432205D2, 8);
            put(16'h0018, 64'h1126, 2);
            put(16'h001A, 64'h0522082818, 5);
            put(16'h001F, 64'h16C21026, 4);
            boot;
            repeat (4) ex(8'h03, 8'h00, 3'h0);
            bank = 2'h1;
            ex(8'h03, 8'h00, 3'h0);
            ex(8'h01, 8'h22, 3'h0);
            repeat (2) ex(8'h03, 8'h22, 3'h0);
            ex(8'h02, 8'h22, 3'h0);
            ex(8'h01, 8'h29, 3'h0);
            ex(8'h02, 8'h29, 3'h0);
            ex(8'h01, 8'h29, 3'h0);
            ex(8'h01, 8'h4C, 3'h0);
            ex(8'h01, 8'h4C, 3'h0);
            ex(8'h01, 8'h4C, 3'h0);
            ex(8'h02, 8'h4C, 3'h0);
            ex(8'h01, 8'h52, 3'h2);
            $display("bank test done");
        end
    endtask
    task t_branch;
        begin
            put(16'h0000, 64'h00A3020100, 5);
            put(16'h0100, 64'h8010, 2);
            put(16'h0112, 64'h4180, 2);
            put(16'h0280, 64'h240383A580805A, 7);
            put(16'h0206, 64'h120010, 3);
            put(16'h0010, 64'h93, 1);
            put(16'h005B, 64'h3C, 1);
            put(16'h0011, 64'h250825097140, 6);
            put(16'h0340, 64'h250A, 2);
            boot;
            step(8'h03);
            cmp16(dataPointerOut, 16'h0001);
            step(8'h03);
            cmp16(codeAddr, 16'h0100);
            step(8'h02);
            cmp16(codeAddr, 16'h0112);
            step(8'h02);
            cmp16(codeAddr, 16'h0280);
            ex(8'h02, 8'h03, 3'h0);
            ex(8'h03, 8'h5A, 3'h0);
            cmp16(codeAddr, 16'h0283);
            step(8'h01);
            cmp8({7'h00, badOpcode}, 8'h01);
            step(8'h02);
            cmp16(codeAddr, 16'h0206);
            step(8'h03);
            cmp16(codeAddr, 16'h0010);
            cmp8(stackOut, 8'h09);
            ex(8'h03, 8'h3C, 3'h0);
            // read back the pushed return address, low byte first
            ex(8'h02, 8'h45, 3'h2);
            ex(8'h02, 8'h47, 3'h0);
            step(8'h02);
            cmp16(codeAddr, 16'h0340);
            cmp8(stackOut, 8'h0B);
            ex(8'h02, 8'h5E, 3'h0);
            $display("branch test done");
        end
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // whole run is under 150 cycles; this limit of 5000 cycles is far beyond it
    initial begin
        #20000;
        miscompares = miscompares + 1;
        print_verdict;
    end
    initial begin
        for (i = 0; i < 65536; i = i + 1)
            rom[i] = 8'h00;
        t_add;
        t_mul;
        t_logic;
        t_bank;
        t_branch;
        print_verdict;
    end
endmodule // tb

// ---- verilog/cpu_arith_logic_decode.v ----
// decode and execute core for arithmetic, logic and branch opcodes
`timescale 1ns/1ps
`include "cpu_arith_logic_defines.vh"

// Function
// - standard opcode bytes are decoded unchanged
// - flags change exactly as the standard set defines, nothing more
// - one instruction cycle is one core clock here
// - cycles equal bytes; data pointer increment and code read three, multiply/divide five
// - register operand picks R0-R7 in the bank chosen by status bits
// - direct below 0x80 hits lower RAM, above hits special registers
// - indirect uses R0 or R1; high pointer values reach upper RAM
// - bit addresses map to bytes 0x20-0x2F and registers 0x80-0xF8
// - relative offset is signed byte added to following address
// - short call/jump keep top five bits of incremented counter
// - long call/jump load a full 16-bit target
// - short branches and the PC-relative code read use the following address
// - plain add updates carry, wrap and half carry
// - add with carry in updates carry, wrap and half carry
// - subtract with borrow updates carry, wrap and half carry
// - multiply: high byte to B, low to A, carry cleared
// - divide: quotient to A, remainder to B, carry cleared
// - logic and into A or direct byte, flags untouched
// - logic or into A or direct byte, flags untouched
// - logic xor into A or direct byte, flags untouched
module cpu_arith_logic_decode (
    input wire clock,
    input wire rst_b,
    input wire [7:0] codeData,
    output reg [15:0] codeAddr,
    output reg [7:0] accOut,
    output reg [7:0] bOut,
    output reg [7:0] statusOut,
    output reg [15:0] dataPointerOut,
    output reg [7:0] stackOut,
    output reg instrDone,
    output reg badOpcode
);

// ----------------------------------------
// length and cycle tables
// ----------------------------------------
function supp;
    input [7:0] o;
    begin
        case (o)
            `OP_NOP, `OP_LONG_JUMP, `OP_LONG_CALL, `OP_REL_JUMP,
            `OP_CODE_READ_PC, `OP_CODE_READ_DP, `OP_DATA_POINTER_INC,
            `OP_PRODUCT, `OP_QUOTIENT, `OP_DEC_ADJUST, `OP_CLEAR_ACC,
            `OP_CPL_ACC, `OP_OR_DIR_ACC, `OP_OR_DIR_IMM,
            `OP_AND_DIR_ACC, `OP_AND_DIR_IMM, `OP_XOR_DIR_ACC,
            `OP_XOR_DIR_IMM, `OP_BIT_CLEAR, `OP_BIT_SET: supp = 1'b1;
            default: supp = (o[3:0] == 4'h1) ||
                ((o[3:0] >= 4'h4) && (o[7:4] <= 4'h6 || o[7:4] == 4'h9));
        endcase
    end
endfunction

function [2:0] lenOf;
    input [7:0] o;
    begin
        if (!supp(o))
            lenOf = 3'd1;
        else if (o[3:0] == 4'h1)
            lenOf = 3'd2;
        else begin
            case (o)
                `OP_LONG_JUMP, `OP_LONG_CALL, `OP_OR_DIR_IMM,
                `OP_AND_DIR_IMM, `OP_XOR_DIR_IMM: lenOf = 3'd3;
                // one-byte x4 opcodes must not fall into the immediate rule
                `OP_PRODUCT, `OP_QUOTIENT, `OP_DEC_ADJUST,
                `OP_CLEAR_ACC, `OP_CPL_ACC: lenOf = 3'd1;
                `OP_REL_JUMP, `OP_OR_DIR_ACC, `OP_AND_DIR_ACC,
                `OP_XOR_DIR_ACC, `OP_BIT_CLEAR, `OP_BIT_SET: lenOf = 3'd2;
                default: lenOf = (o[3:0] == 4'h5 ||
                    (o[3:0] == 4'h4 && o[7:4] >= 4'h2)) ? 3'd2 : 3'd1;
            endcase
        end
    end
endfunction

// extra cycles only where the table adds them
function [2:0] cycOf;
    input [7:0] o;
    begin
        case (o)
            `OP_DATA_POINTER_INC: cycOf = `CYC_DATA_POINTER_INC;
            `OP_PRODUCT, `OP_QUOTIENT: cycOf = `CYC_MULDIV;
            `OP_CODE_READ_PC, `OP_CODE_READ_DP: cycOf = `CYC_CODE_READ;
            default: cycOf = lenOf(o);
        endcase
    end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg [7:0] ram [0:255];
reg [15:0] pc_r;
reg [2:0] cnt_r;
reg [7:0] opc_r;
reg [7:0] arg1_r;
reg [15:0] ret_r;

// opcode and first operand are used in the cycle they arrive
wire [7:0] opc = (cnt_r == 3'd0) ? codeData : opc_r;
wire [7:0] arg1 = (cnt_r == 3'd1) ? codeData : arg1_r;
wire [7:0] arg2 = codeData;
wire [3:0] hi = opc[7:4];
wire [3:0] lo = opc[3:0];
wire [2:0] len = lenOf(opc);
wire last = (cnt_r == cycOf(opc) - 3'd1);
wire isCall = (opc == `OP_LONG_CALL) || (lo == 4'h1 && opc[4]);
wire isCr = (opc == `OP_CODE_READ_PC) || (opc == `OP_CODE_READ_DP);
wire cy = statusOut[`PSW_CARRY];
wire [7:0] rnA = {3'b000, statusOut[4:3], opc[2:0]};
wire [7:0] ptrA = {3'b000, statusOut[4:3], 2'b00, opc[0]};
wire [7:0] ptr = ram[ptrA];
wire [7:0] rnVal = ram[rnA];
wire [7:0] indVal = ram[ptr];
// bit address to its byte: ram 0x20-0x2F or register at multiple of 8
wire [7:0] bitByte = arg1[7] ? {arg1[7:3], 3'b000} :
    {4'h2, arg1[6:3]};
wire isBit = (opc == `OP_BIT_CLEAR) || (opc == `OP_BIT_SET);
wire [7:0] rdA = isBit ? bitByte : arg1;

// ----------------------------------------
// direct and operand reads
// ----------------------------------------
reg [7:0] dirVal;
reg [7:0] src;
always @* begin
    if (!rdA[7])
        dirVal = ram[rdA];
    else begin
        case (rdA)
            `SFR_ACC: dirVal = accOut;
            `SFR_B: dirVal = bOut;
            `SFR_PSW: dirVal = statusOut;
            `SFR_SP: dirVal = stackOut;
            `SFR_DPL: dirVal = dataPointerOut[7:0];
            `SFR_DPH: dirVal = dataPointerOut[15:8];
            default: dirVal = 8'h00; // unmapped registers read zero
        endcase
    end
    if (lo[3])
        src = rnVal;
    else if (lo == 4'h5)
        src = dirVal;
    else if (lo[3:1] == 3'b011)
        src = indVal;
    else
        src = (hi >= 4'h2) ? arg1 : accOut;
end

// ----------------------------------------
// execute: next values of every register
// ----------------------------------------
reg [7:0] accN, bN, pswN, spN, dD, dA, ramA, ramD, res;
reg [15:0] pcN, dptrN, codeAddrN, prod;
reg [8:0] t9, u9;
reg [4:0] t5;
reg ramWe, dWe, cyDa;
always @* begin
    accN = accOut;
    bN = bOut;
    pswN = statusOut;
    spN = stackOut;
    dptrN = dataPointerOut;
    pcN = pc_r;
    ramWe = 1'b0;
    ramA = 8'h00;
    ramD = 8'h00;
    dWe = 1'b0;
    dA = arg1;
    dD = 8'h00;
    res = 8'h00;
    prod = 16'h0000;
    t9 = 9'h000;
    u9 = 9'h000;
    t5 = 5'h00;
    cyDa = 1'b0;
    // one code byte consumed per cycle until the length is reached
    if ({1'b0, cnt_r} < {1'b0, len})
        pcN = pc_r + 16'h0001;
    // return address goes on the stack low byte first
    if (isCall && cnt_r == 3'd0) begin
        ramWe = 1'b1;
        ramA = stackOut + 8'h01;
        ramD = pc_r[7:0] + {5'b00000, len};
        spN = stackOut + 8'h01;
    end else if (isCall && cnt_r == 3'd1) begin
        ramWe = 1'b1;
        ramA = stackOut + 8'h01;
        ramD = ret_r[15:8];
        spN = stackOut + 8'h01;
    end
    if (last && lo == 4'h1) begin
        pcN = {pcN[15:11], opc[7:5], arg1};
    end else if (last) begin
        case (opc)
            `OP_LONG_JUMP, `OP_LONG_CALL: pcN = {arg1, arg2};
            `OP_REL_JUMP: pcN = pcN + {{8{arg1[7]}}, arg1};
            `OP_CODE_READ_PC, `OP_CODE_READ_DP: accN = codeData;
            `OP_DATA_POINTER_INC: dptrN = dataPointerOut + 16'h0001;
            `OP_PRODUCT: begin
                prod = accOut * bOut;
                accN = prod[7:0];
                bN = prod[15:8];
                pswN[`PSW_CARRY] = 1'b0;
                pswN[`PSW_WRAP] = |prod[15:8];
            end
            `OP_QUOTIENT: begin
                // divide by zero leaves A and B as they were
                if (bOut != 8'h00) begin
                    accN = accOut / bOut;
                    bN = accOut % bOut;
                end
                pswN[`PSW_CARRY] = 1'b0;
                pswN[`PSW_WRAP] = (bOut == 8'h00);
            end
            `OP_DEC_ADJUST: begin
                t9 = {1'b0, accOut} + ((accOut[3:0] > 4'h9 ||
                    statusOut[`PSW_HALF]) ? 9'h006 : 9'h000);
                cyDa = cy | t9[8];
                u9 = {1'b0, t9[7:0]} + ((t9[7:4] > 4'h9 || cyDa) ?
                    9'h060 : 9'h000);
                accN = u9[7:0];
                pswN[`PSW_CARRY] = cyDa | u9[8]; // carry never cleared
            end
            `OP_CLEAR_ACC: accN = 8'h00;
            `OP_CPL_ACC: accN = ~accOut;
            `OP_OR_DIR_ACC, `OP_OR_DIR_IMM,
            `OP_AND_DIR_ACC, `OP_AND_DIR_IMM,
            `OP_XOR_DIR_ACC, `OP_XOR_DIR_IMM: begin
                res = opc[0] ? arg2 : accOut;
                dWe = 1'b1;
                if (hi == 4'h4)
                    dD = dirVal | res;
                else if (hi == 4'h5)
                    dD = dirVal & res;
                else
                    dD = dirVal ^ res;
            end
            `OP_BIT_CLEAR, `OP_BIT_SET: begin
                dWe = 1'b1;
                dA = bitByte;
                dD = opc[4] ? (dirVal | (8'h01 << arg1[2:0])) :
                    (dirVal & ~(8'h01 << arg1[2:0]));
            end
            default: begin
                if (supp(opc) && lo >= 4'h4) begin
                    case (hi)
                        4'h0, 4'h1: begin
                            // no flag is touched by inc or dec
                            res = (hi == 4'h0) ? src + 8'h01 :
                                src - 8'h01;
                            if (lo == 4'h4)
                                accN = res;
                            else if (lo == 4'h5) begin
                                dWe = 1'b1;
                                dD = res;
                            end else begin
                                ramWe = 1'b1;
                                ramA = lo[3] ? rnA : ptr;
                                ramD = res;
                            end
                        end
                        4'h2, 4'h3: begin
                            res = {7'h00, hi[0] & cy};
                            t9 = {1'b0, accOut} + {1'b0, src} +
                                {1'b0, res};
                            t5 = {1'b0, accOut[3:0]} + {1'b0, src[3:0]} +
                                {1'b0, res[3:0]};
                            accN = t9[7:0];
                            pswN[`PSW_CARRY] = t9[8];
                            pswN[`PSW_HALF] = t5[4];
                            pswN[`PSW_WRAP] = (accOut[7] == src[7]) &&
                                (t9[7] != accOut[7]);
                        end
                        4'h9: begin
                            t9 = {1'b0, accOut} - {1'b0, src} -
                                {8'h00, cy};
                            t5 = {1'b0, accOut[3:0]} - {1'b0, src[3:0]} -
                                {4'h0, cy};
                            accN = t9[7:0];
                            pswN[`PSW_CARRY] = t9[8];
                            pswN[`PSW_HALF] = t5[4];
                            pswN[`PSW_WRAP] = (accOut[7] != src[7]) &&
                                (t9[7] != accOut[7]);
                        end
                        4'h4: accN = accOut | src;
                        4'h5: accN = accOut & src;
                        4'h6: accN = accOut ^ src;
                        default: accN = accOut;
                    endcase
                end
            end
        endcase
    end
    // a direct write lands in lower RAM or a special register
    if (dWe) begin
        if (!dA[7]) begin
            ramWe = 1'b1;
            ramA = dA;
            ramD = dD;
        end else begin
            case (dA)
                `SFR_ACC: accN = dD;
                `SFR_B: bN = dD;
                `SFR_PSW: pswN = dD;
                `SFR_SP: spN = dD;
                `SFR_DPL: dptrN[7:0] = dD;
                `SFR_DPH: dptrN[15:8] = dD;
                default: ; // writes to unmapped space dropped
            endcase
        end
    end
    pswN[0] = ^accN; // parity always follows the accumulator
    // code read holds its data address for two cycles
    if (isCr && cnt_r == 3'd0)
        codeAddrN = accOut + ((opc == `OP_CODE_READ_PC) ?
            pcN : dataPointerOut);
    else if (isCr && cnt_r == 3'd1)
        codeAddrN = codeAddr;
    else
        codeAddrN = pcN;
end

// ----------------------------------------
// registers
// ----------------------------------------
// internal RAM holds data only, so it is left out of reset
always @(posedge clock) begin
    if (ramWe && rst_b) // no stray writes while held in reset
        ram[ramA] <= ramD;
end

always @(posedge clock) begin
    if (!rst_b) begin
        pc_r <= `RST_PC;
        codeAddr <= `RST_PC;
        cnt_r <= 3'd0;
        opc_r <= 8'h00;
        arg1_r <= 8'h00;
        ret_r <= 16'h0000;
        accOut <= 8'h00;
        bOut <= 8'h00;
        statusOut <= 8'h00;
        dataPointerOut <= 16'h0000;
        stackOut <= `RST_SP;
        instrDone <= 1'b0;
        badOpcode <= 1'b0;
    end else begin
        pc_r <= pcN;
        codeAddr <= codeAddrN;
        cnt_r <= last ? 3'd0 : cnt_r + 3'd1;
        if (cnt_r == 3'd0)
            opc_r <= codeData;
        if (cnt_r == 3'd1)
            arg1_r <= codeData;
        if (cnt_r == 3'd0)
            ret_r <= pc_r + {13'h0000, len};
        accOut <= accN;
        bOut <= bN;
        statusOut <= pswN;
        dataPointerOut <= dptrN;
        stackOut <= spN;
        instrDone <= last;
        badOpcode <= last && !supp(opc);
    end
end

endmodule // cpu_arith_logic_decode
